// file: hw/rnm_pkg.sv
// Constants for the ring node management frame handler.
// Assumes a 10 MHz system clock and one word-wide register port.
package rnm_pkg;
  localparam int NODES = 8;
  localparam int NID_W = 3;
  localparam int TRIBS = 8;
  localparam int TMR_W = 24;
  localparam int LIM_W = 4;
  localparam int REL_W = 24;
  // Register offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_TARGETS = 8'h04;
  localparam logic [7:0] A_REQDATA = 8'h08;
  localparam logic [7:0] A_RETRY   = 8'h0c;
  localparam logic [7:0] A_LIMIT   = 8'h10;
  localparam logic [7:0] A_TGTSTAT = 8'h14;
  localparam logic [7:0] A_ISTAT   = 8'h18;
  localparam logic [7:0] A_IMASK   = 8'h1c;
  localparam logic [7:0] A_DESIG   = 8'h20;
  localparam logic [7:0] A_THRESH  = 8'h24;
  localparam logic [7:0] A_STATE   = 8'h28;
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_NULL  = 1;
  localparam int IDX_LSB    = 24;
  localparam int IRQ_W      = 5;
  localparam int IRQ_OK     = 0;
  localparam int IRQ_LOST   = 1;
  localparam int IRQ_INST   = 2;
  localparam int IRQ_FREQ   = 3;
  localparam int IRQ_SWITCH = 4;
  // Reset values
  localparam logic [TMR_W-1:0] RETRY_RST = 24'h002710;
  localparam logic [LIM_W-1:0] LIMIT_RST = 4'h3;
  localparam logic [7:0]       THRESH_RST = 8'h80;
  // Frame types
  localparam logic [3:0] FT_CFG_REQ = 4'h1;
  localparam logic [3:0] FT_CFG_RSP = 4'h2;
  localparam logic [3:0] FT_FLT_REP = 4'h3;
  localparam logic [3:0] FT_FLT_REQ = 4'h4;
  localparam logic [3:0] FT_FLT_RSP = 4'h5;
  localparam logic [3:0] FT_PRF_REP = 4'h6;
  localparam logic [3:0] FT_PRF_REQ = 4'h7;
  localparam logic [3:0] FT_PRF_RSP = 4'h8;
  // Monitoring periods
  localparam longint CLK_HZ       = 10_000_000;
  localparam longint TICK_S       = 1;
  localparam longint TICK_CYC     = CLK_HZ * TICK_S;
  localparam longint SHORT_MIN    = 15;
  localparam longint LONG_H       = 24;
  localparam longint SHORT_SEC    = SHORT_MIN * 60;
  localparam longint LONG_SEC     = LONG_H * 3600;
endpackage

// file: hw/rnm_retry.sv
// Retry timer and count for one configuration target.
// Assumes i_start, i_ack and i_resp are one-cycle pulses on i_sys_clk.
`timescale 1ns/100ps
module rnm_retry (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_ce,
  input  wire logic                     i_start,
  input  wire logic                     i_ack,
  input  wire logic                     i_resp,
  input  wire logic [rnm_pkg::TMR_W-1:0] i_period,
  input  wire logic [rnm_pkg::LIM_W-1:0] i_limit,
  output logic                          o_want,
  output logic                          o_busy,
  output logic                          o_ok,
  output logic                          o_lost
);
  logic [rnm_pkg::TMR_W-1:0] tmr_r;
  logic [rnm_pkg::LIM_W-1:0] cnt_r;
  logic                      want_r, busy_r, ok_r, lost_r;
  wire expire = busy_r && (tmr_r <= 24'h000001);
  wire spent  = cnt_r >= i_limit;
  assign o_want = want_r;
  assign o_busy = busy_r;
  assign o_ok   = ok_r;
  assign o_lost = lost_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tmr_r  <= '0;
      cnt_r  <= '0;
      want_r <= 1'b0;
      busy_r <= 1'b0;
      ok_r   <= 1'b0;
      lost_r <= 1'b0;
    end
    else if (i_ce)
    begin
      ok_r   <= 1'b0;
      lost_r <= 1'b0;
      if (i_start)
      begin
        busy_r <= 1'b1;
        tmr_r  <= i_period;
        cnt_r  <= '0;
        want_r <= 1'b0;
      end
      else if (busy_r && i_resp)
      begin
        busy_r <= 1'b0;
        want_r <= 1'b0;
        ok_r   <= 1'b1;
      end
      else if (expire)
      begin
        tmr_r <= i_period;
        if (spent)
        begin
          busy_r <= 1'b0;
          want_r <= 1'b0;
          lost_r <= 1'b1;
        end
        else
        begin
          cnt_r  <= cnt_r + 4'h1;
          want_r <= 1'b1;
        end
      end
      else
      begin
        tmr_r <= tmr_r - 24'h000001;
        if (i_ack)
          want_r <= 1'b0;
      end
    end
  end

  property p_resend;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    expire && !spent && !i_start && !i_resp |=> want_r && busy_r;
  endproperty
  a_resend: assert property (p_resend) else $error("no resend on expiry");
  property p_lost;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    expire && spent && !i_start && !i_resp |=> lost_r && !busy_r;
  endproperty
  a_lost: assert property (p_lost) else $error("limit not honoured");
  property p_ok;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    busy_r && i_resp && !i_start |=> ok_r && !busy_r && !want_r;
  endproperty
  a_ok: assert property (p_ok) else $error("response not taken");
endmodule

// file: hw/rnm_top.sv
// Management frame handler: config table, fault, performance, standby.
// Assumes rx frames are pre-filtered for this node, one per strobe.
`timescale 1ns/100ps
module rnm_top #(
  parameter longint P_TICK_CYC  = rnm_pkg::TICK_CYC,
  parameter longint P_SHORT_SEC = rnm_pkg::SHORT_SEC,
  parameter longint P_LONG_SEC  = rnm_pkg::LONG_SEC
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_ce,
  input  wire logic [7:0]               i_addr,
  input  wire logic [31:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [31:0]              o_rdata,
  output logic                          o_irq,
  input  wire logic                     i_rx_valid,
  input  wire logic [3:0]               i_rx_type,
  input  wire logic [rnm_pkg::NID_W-1:0] i_rx_src,
  input  wire logic                     i_rx_null,
  input  wire logic [31:0]              i_rx_data,
  output logic                          o_tx_valid,
  input  wire logic                     i_tx_ready,
  output logic      [3:0]               o_tx_type,
  output logic      [rnm_pkg::NID_W-1:0] o_tx_dst,
  output logic                          o_tx_bcast,
  output logic      [31:0]              o_tx_data,
  input  wire logic                     i_fault,
  input  wire logic [7:0]               i_fault_code,
  input  wire logic [31:0]              i_perf_param,
  input  wire logic [rnm_pkg::TRIBS-1:0] i_tsf_work,
  input  wire logic [rnm_pkg::TRIBS-1:0] i_tsf_prot,
  input  wire logic [8*rnm_pkg::TRIBS-1:0] i_work_err,
  output logic                          o_trib_en,
  output logic      [rnm_pkg::TRIBS-1:0] o_sel_prot
);
  localparam int N = rnm_pkg::NODES;
  localparam int T = rnm_pkg::TRIBS;
  localparam logic [39:0] TICK_END  = 40'(P_TICK_CYC - 1);
  localparam logic [19:0] SHORT_END = 20'(P_SHORT_SEC - 1);
  localparam logic [19:0] LONG_END  = 20'(P_LONG_SEC - 1);

  // Registers
  logic [N-1:0]                targets_r, ok_r, lost_r;
  logic [31:0]                 reqdata_r, rdata_r, rd_mux;
  logic                        reqnull_r;
  logic [rnm_pkg::TMR_W-1:0]   retry_r;
  logic [rnm_pkg::LIM_W-1:0]   limit_r;
  logic [rnm_pkg::IRQ_W-1:0]   istat_r, imask_r, istat_nxt;
  logic [rnm_pkg::NID_W-1:0]   desig_r, rsp_dst_r;
  logic [7:0]                  thresh_r;
  logic [rnm_pkg::REL_W-1:0]   xc_tab [N];
  logic                        inst_r;
  logic [31:0]                 rsp_data_r;
  logic                        cfg_rsp_p, flt_rsp_p, prf_rsp_p, flt_rep_p, prf_rep_p, req_p;
  logic [rnm_pkg::NID_W-1:0]   flt_dst_r, prf_dst_r;
  logic [T-1:0]                tsfw_m, tsfw_s, tsfp_m, tsfp_s, sel_r;
  logic [2:0]                  flt_sync;
  logic [39:0]                 tick_r;
  logic [19:0]                 sec_s_r, sec_l_r;
  logic                        tx_v_r, tx_bc_r;
  logic [3:0]                  tx_t_r;
  logic [rnm_pkg::NID_W-1:0]   tx_d_r;
  logic [31:0]                 tx_dat_r;
  logic [N-1:0]                want, busy, ok_p, lost_p, ack;
  logic [T-1:0]                fail, sel_nxt;

  // Register port decode
  wire wr_ctrl  = i_wr && i_addr == rnm_pkg::A_CTRL;
  wire start    = wr_ctrl && i_wdata[rnm_pkg::CTRL_START];
  wire rd_istat = i_rd && i_addr == rnm_pkg::A_ISTAT;

  // Received frame decode
  wire rx_cfg    = i_rx_valid && i_rx_type == rnm_pkg::FT_CFG_REQ;
  wire rx_setup  = rx_cfg && !i_rx_null;
  wire rx_query  = rx_cfg && i_rx_null;
  wire rx_rsp    = i_rx_valid && i_rx_type == rnm_pkg::FT_CFG_RSP && i_rx_null;
  wire rx_fltreq = i_rx_valid && i_rx_type == rnm_pkg::FT_FLT_REQ;
  wire rx_prfreq = i_rx_valid && i_rx_type == rnm_pkg::FT_PRF_REQ;
  wire [rnm_pkg::NID_W-1:0] rx_idx = i_rx_data[rnm_pkg::IDX_LSB +: rnm_pkg::NID_W];
  wire fault_edge = flt_sync[1] && !flt_sync[2];
  wire tick_end   = tick_r == TICK_END;
  wire per_short  = tick_end && sec_s_r == SHORT_END;
  wire per_long   = tick_end && sec_l_r == LONG_END;

  // Transmit arbitration: answers first, then reports, then requests
  wire load     = !tx_v_r || i_tx_ready;
  wire any_want = |want;
  wire g_crsp = load && cfg_rsp_p;
  wire g_frsp = load && !cfg_rsp_p && flt_rsp_p;
  wire g_prsp = load && !cfg_rsp_p && !flt_rsp_p && prf_rsp_p;
  wire hi3    = cfg_rsp_p || flt_rsp_p || prf_rsp_p;
  wire g_frep = load && !hi3 && flt_rep_p;
  wire g_prep = load && !hi3 && !flt_rep_p && prf_rep_p;
  wire hi5    = hi3 || flt_rep_p || prf_rep_p;
  wire g_req  = load && !hi5 && req_p;
  wire g_rsnd = load && !hi5 && !req_p && any_want;
  logic [rnm_pkg::NID_W-1:0] want_id;
  always_comb
  begin
    want_id = '0;
    for (int i = N - 1; i >= 0; i--)
      if (want[i])
        want_id = rnm_pkg::NID_W'(i);
  end
  assign ack = g_rsnd ? (N'(1) << want_id) : '0;
  wire [rnm_pkg::NID_W-1:0] rel_idx = reqdata_r[rnm_pkg::IDX_LSB +: rnm_pkg::NID_W];

  // One retry engine per target
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_tgt
      rnm_retry u_retry (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_start   (g_req && targets_r[g] && !reqnull_r),
        .i_ack     (ack[g]),
        .i_resp    (rx_rsp && i_rx_src == rnm_pkg::NID_W'(g)),
        .i_period  (retry_r),
        .i_limit   (limit_r),
        .o_want    (want[g]),
        .o_busy    (busy[g]),
        .o_ok      (ok_p[g]),
        .o_lost    (lost_p[g])
      );
    end
  endgenerate

  // Standby selection, each tributary decided on its own
  always_comb
  begin
    for (int i = 0; i < T; i++)
    begin
      fail[i]    = tsfw_s[i] || (i_work_err[8*i +: 8] > thresh_r);
      sel_nxt[i] = fail[i] && !tsfp_s[i];
    end
  end

  always_comb
  begin
    istat_nxt = rd_istat ? '0 : istat_r;
    istat_nxt[rnm_pkg::IRQ_OK]     = istat_nxt[rnm_pkg::IRQ_OK] | (|ok_p);
    istat_nxt[rnm_pkg::IRQ_LOST]   = istat_nxt[rnm_pkg::IRQ_LOST] | (|lost_p);
    istat_nxt[rnm_pkg::IRQ_INST]   = istat_nxt[rnm_pkg::IRQ_INST] | rx_setup;
    istat_nxt[rnm_pkg::IRQ_FREQ]   = istat_nxt[rnm_pkg::IRQ_FREQ] | rx_fltreq;
    istat_nxt[rnm_pkg::IRQ_SWITCH] = istat_nxt[rnm_pkg::IRQ_SWITCH] | (|(sel_nxt ^ sel_r));
  end

  always_comb
  begin
    case (i_addr)
      rnm_pkg::A_CTRL:    rd_mux = {30'h0, reqnull_r, req_p};
      rnm_pkg::A_TARGETS: rd_mux = 32'(targets_r);
      rnm_pkg::A_REQDATA: rd_mux = reqdata_r;
      rnm_pkg::A_RETRY:   rd_mux = 32'(retry_r);
      rnm_pkg::A_LIMIT:   rd_mux = 32'(limit_r);
      rnm_pkg::A_TGTSTAT: rd_mux = {8'h0, busy, lost_r, ok_r};
      rnm_pkg::A_ISTAT:   rd_mux = 32'(istat_r);
      rnm_pkg::A_IMASK:   rd_mux = 32'(imask_r);
      rnm_pkg::A_DESIG:   rd_mux = 32'(desig_r);
      rnm_pkg::A_THRESH:  rd_mux = 32'(thresh_r);
      rnm_pkg::A_STATE:   rd_mux = {23'h0, inst_r, sel_r};
      default:            rd_mux = 32'h0;
    endcase
  end
  // Read data stands only in the cycle after the read strobe
  assign o_rdata    = rdata_r;
  assign o_irq      = |(istat_r & imask_r);
  assign o_trib_en  = inst_r;
  assign o_sel_prot = sel_r;
  assign o_tx_valid = tx_v_r;
  assign o_tx_type  = tx_t_r;
  assign o_tx_dst   = tx_d_r;
  assign o_tx_bcast = tx_bc_r;
  assign o_tx_data  = tx_dat_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      targets_r <= '0;
      reqdata_r <= '0;
      reqnull_r <= 1'b0;
      retry_r   <= rnm_pkg::RETRY_RST;
      limit_r   <= rnm_pkg::LIMIT_RST;
      imask_r   <= '0;
      desig_r   <= '0;
      thresh_r  <= rnm_pkg::THRESH_RST;
      istat_r   <= '0;
      rdata_r   <= '0;
      ok_r      <= '0;
      lost_r    <= '0;
    end
    else if (i_ce)
    begin
      istat_r <= istat_nxt;
      rdata_r <= i_rd ? rd_mux : 32'h0;
      ok_r   <= (start ? '0 : ok_r) | ok_p;
      lost_r <= (start ? '0 : lost_r) | lost_p;
      if (i_wr)
        case (i_addr)
          rnm_pkg::A_CTRL:    reqnull_r <= i_wdata[rnm_pkg::CTRL_NULL];
          rnm_pkg::A_TARGETS: targets_r <= i_wdata[N-1:0];
          rnm_pkg::A_REQDATA: reqdata_r <= i_wdata;
          rnm_pkg::A_RETRY:   retry_r   <= i_wdata[rnm_pkg::TMR_W-1:0];
          rnm_pkg::A_LIMIT:   limit_r   <= i_wdata[rnm_pkg::LIM_W-1:0];
          rnm_pkg::A_IMASK:   imask_r   <= i_wdata[rnm_pkg::IRQ_W-1:0];
          rnm_pkg::A_DESIG:   desig_r   <= i_wdata[rnm_pkg::NID_W-1:0];
          rnm_pkg::A_THRESH:  thresh_r  <= i_wdata[7:0];
          default:            ;
        endcase
    end
  end

  always_ff @(posedge i_sys_clk)
    if (i_ce && rx_setup)
      xc_tab[rx_idx] <= i_rx_data[rnm_pkg::REL_W-1:0];

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      inst_r     <= 1'b0;
      cfg_rsp_p  <= 1'b0;
      flt_rsp_p  <= 1'b0;
      prf_rsp_p  <= 1'b0;
      flt_rep_p  <= 1'b0;
      prf_rep_p  <= 1'b0;
      req_p      <= 1'b0;
      rsp_dst_r  <= '0;
      rsp_data_r <= '0;
      flt_dst_r  <= '0;
      prf_dst_r  <= '0;
      flt_sync   <= '0;
      tsfw_m     <= '0;
      tsfw_s     <= '0;
      tsfp_m     <= '0;
      tsfp_s     <= '0;
      sel_r      <= '0;
      tick_r     <= '0;
      sec_s_r    <= '0;
      sec_l_r    <= '0;
    end
    else if (i_ce)
    begin
      flt_sync <= {flt_sync[1:0], i_fault};
      tsfw_m   <= i_tsf_work;
      tsfw_s   <= tsfw_m;
      tsfp_m   <= i_tsf_prot;
      tsfp_s   <= tsfp_m;
      sel_r    <= sel_nxt;
      inst_r   <= inst_r | rx_setup;
      tick_r   <= tick_end ? '0 : tick_r + 40'h1;
      if (tick_end)
      begin
        sec_s_r <= (sec_s_r == SHORT_END) ? '0 : sec_s_r + 20'h1;
        sec_l_r <= (sec_l_r == LONG_END) ? '0 : sec_l_r + 20'h1;
      end
      // Each pending flag: a new event wins over its own grant
      cfg_rsp_p <= rx_cfg | (cfg_rsp_p & ~g_crsp);
      flt_rsp_p <= rx_fltreq | (flt_rsp_p & ~g_frsp);
      prf_rsp_p <= rx_prfreq | (prf_rsp_p & ~g_prsp);
      flt_rep_p <= fault_edge | (flt_rep_p & ~g_frep);
      prf_rep_p <= per_short | per_long | (prf_rep_p & ~g_prep);
      req_p     <= start | (req_p & ~g_req);
      if (rx_cfg)
      begin
        rsp_dst_r  <= i_rx_src;
        rsp_data_r <= rx_query ? {5'h0, rx_idx, xc_tab[rx_idx]} : 32'h0;
      end
      if (rx_fltreq)
        flt_dst_r <= i_rx_src;
      if (rx_prfreq)
        prf_dst_r <= i_rx_src;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_v_r   <= 1'b0;
      tx_bc_r  <= 1'b0;
      tx_t_r   <= '0;
      tx_d_r   <= '0;
      tx_dat_r <= '0;
    end
    else if (i_ce && load)
    begin
      tx_v_r  <= hi5 || req_p || any_want;
      tx_bc_r <= g_req;
      if (g_crsp)
      begin
        tx_t_r   <= rnm_pkg::FT_CFG_RSP;
        tx_d_r   <= rsp_dst_r;
        tx_dat_r <= rsp_data_r;
      end
      else if (g_frsp || g_frep)
      begin
        tx_t_r   <= g_frsp ? rnm_pkg::FT_FLT_RSP : rnm_pkg::FT_FLT_REP;
        tx_d_r   <= g_frsp ? flt_dst_r : desig_r;
        tx_dat_r <= {24'h0, i_fault_code};
      end
      else if (g_prsp || g_prep)
      begin
        tx_t_r   <= g_prsp ? rnm_pkg::FT_PRF_RSP : rnm_pkg::FT_PRF_REP;
        tx_d_r   <= g_prsp ? prf_dst_r : desig_r;
        tx_dat_r <= i_perf_param;
      end
      else if (g_req || g_rsnd)
      begin
        tx_t_r   <= rnm_pkg::FT_CFG_REQ;
        tx_d_r   <= g_req ? '0 : want_id;
        tx_dat_r <= reqnull_r ? {5'h0, rel_idx, 24'h0} : reqdata_r;
      end
    end
  end

  property p_setup;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    rx_setup |=> o_trib_en && cfg_rsp_p && rsp_data_r == 32'h0;
  endproperty
  a_setup: assert property (p_setup) else $error("setup not answered");
  property p_idle;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    !inst_r && !rx_setup |=> !o_trib_en;
  endproperty
  a_idle: assert property (p_idle) else $error("trib enabled early");
  property p_query;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    rx_query |=> cfg_rsp_p && rsp_dst_r == $past(i_rx_src);
  endproperty
  a_query: assert property (p_query) else $error("inquiry not answered");
  property p_fault;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    fault_edge |=> flt_rep_p;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not reported");
  property p_fltreq;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    rx_fltreq |=> flt_rsp_p && flt_dst_r == $past(i_rx_src);
  endproperty
  a_fltreq: assert property (p_fltreq) else $error("fault request lost");
  property p_perf;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    per_short || per_long |=> prf_rep_p;
  endproperty
  a_perf: assert property (p_perf) else $error("period report lost");
  property p_prfreq;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    rx_prfreq |=> prf_rsp_p && prf_dst_r == $past(i_rx_src);
  endproperty
  a_prfreq: assert property (p_prfreq) else $error("perf request lost");
  property p_switch;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    tsfw_s[3] && !tsfp_s[3] |=> o_sel_prot[3];
  endproperty
  a_switch: assert property (p_switch) else $error("no switch on fail");
  property p_bcast;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !i_ce)
    g_req |=> o_tx_valid && o_tx_bcast && o_tx_type == rnm_pkg::FT_CFG_REQ;
  endproperty
  a_bcast: assert property (p_bcast) else $error("request not broadcast");
endmodule

// file: verif/rnm_peer.sv
// Peer ring nodes: take tx frames, log them, send rx frames, answer config requests.
// Assumes the handler's clock; the bench calls send and reads q.
`timescale 1ns/100ps
module rnm_peer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_tx_valid,
  output logic             o_tx_ready = 1'b0,
  input  wire logic [3:0]  i_tx_type,
  input  wire logic [2:0]  i_tx_dst,
  input  wire logic        i_tx_bcast,
  input  wire logic [31:0] i_tx_data,
  output logic             o_rx_valid = 1'b0,
  output logic [3:0]       o_rx_type = 4'h0,
  output logic [2:0]       o_rx_src = 3'h0,
  output logic             o_rx_null = 1'b0,
  output logic [31:0]      o_rx_data = 32'h0
);
  logic [39:0] q[$];
  logic [7:0]  ans_mask = 8'h00;
  logic        slow = 1'b0;
  int          ph = 0;
  task automatic send(input logic [3:0] t, input logic [2:0] s, input logic n,
                      input logic [31:0] d);
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b1;
    o_rx_type  <= t;
    o_rx_src   <= s;
    o_rx_null  <= n;
    o_rx_data  <= d;
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b0;
    // Released fields show the inverse, never the last value
    o_rx_type  <= ~t;
    o_rx_src   <= ~s;
    o_rx_null  <= ~n;
    o_rx_data  <= ~d;
  endtask
  always @(posedge i_sys_clk)
  begin
    ph <= ph + 1;
    o_tx_ready <= !slow || (ph % 3 == 0);
    if (i_tx_valid && o_tx_ready)
      q.push_back({i_tx_type, i_tx_dst, i_tx_bcast, i_tx_data});
  end
  // Chosen nodes answer a config request point-to-point with a null response
  initial
  begin
    logic [7:0] m;
    forever
    begin
      @(posedge i_sys_clk);
      m = ans_mask & (i_tx_bcast ? 8'hff : 8'h01 << i_tx_dst);
      if (i_tx_valid && o_tx_ready && i_tx_type == rnm_pkg::FT_CFG_REQ)
        for (int n = 0; n < 8; n++)
          if (m[n])
            send(rnm_pkg::FT_CFG_RSP, n[2:0], 1'b1, 32'h0);
    end
  end
endmodule

// file: verif/rnm_top_tb.sv
// Self-checking bench for the management frame handler.
// Assumes rnm_peer on the frame side; bus and pins driven here.
`timescale 1ns/100ps
module rnm_top_tb;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, fault = 0, ce = 1, irq, trib_en;
  logic        rxv, rxn, txv, txr, txb;
  logic [7:0]  addr = 0, fcode = 0, tributary_signal_fail = 0, tsfp = 0, sel;
  logic [31:0] wdata = 0, rdata, rxd, txd, d;
  logic [3:0]  rxt, txt;
  logic [2:0]  rxs, txs;
  logic [63:0] werr = 0;
  logic [39:0] f;
  int          errors = 0, n_tests = 0;
  time         t1;
  always #50 clk = ~clk;
  rnm_top #(.P_TICK_CYC(10), .P_SHORT_SEC(3), .P_LONG_SEC(7)) i_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_rx_valid(rxv),
    .i_rx_type(rxt), .i_rx_src(rxs), .i_rx_null(rxn), .i_rx_data(rxd),
    .o_tx_valid(txv), .i_tx_ready(txr), .o_tx_type(txt), .o_tx_dst(txs),
    .o_tx_bcast(txb), .o_tx_data(txd), .i_fault(fault), .i_fault_code(fcode),
    .i_perf_param(32'hc0ffee01), .i_tsf_work(tributary_signal_fail), .i_tsf_prot(tsfp),
    .i_work_err(werr), .o_trib_en(trib_en), .o_sel_prot(sel));
  rnm_peer i_peer (
    .i_sys_clk(clk), .i_tx_valid(txv), .o_tx_ready(txr), .i_tx_type(txt),
    .i_tx_dst(txs), .i_tx_bcast(txb), .i_tx_data(txd), .o_rx_valid(rxv),
    .o_rx_type(rxt), .o_rx_src(rxs), .o_rx_null(rxn), .o_rx_data(rxd));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdata & m, e);
  endtask
  // Next logged frame of type t, other kinds skipped
  task automatic get(input logic [3:0] t);
    f = 'x;
    t1 = $time;
    repeat (400)
    begin
      @(posedge clk);
      while (i_peer.q.size() > 0 && f[39:36] !== t)
        f = i_peer.q.pop_front();
      if (f[39:36] === t)
        return;
    end
  endtask
  task automatic t_reset();
    chk(trib_en, 0);
    rchk(rnm_pkg::A_RETRY, 32'h2710);
    rchk(rnm_pkg::A_LIMIT, 32'h3);
    rchk(rnm_pkg::A_THRESH, 32'h80);
    rchk(8'h3c, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_setup();
    i_peer.slow = 1'b1;
    i_peer.send(rnm_pkg::FT_CFG_REQ, 3'd3, 1'b0, 32'h02abcdef);
    get(rnm_pkg::FT_CFG_RSP);
    chk(f[39:32], {rnm_pkg::FT_CFG_RSP, 3'd3, 1'b0});
    chk(trib_en, 1);
    i_peer.send(rnm_pkg::FT_CFG_REQ, 3'd3, 1'b1, 32'h02000000);
    get(rnm_pkg::FT_CFG_RSP);
    chk(f & 40'hff07ffffff, {rnm_pkg::FT_CFG_RSP, 4'h6, 32'h02abcdef});
    i_peer.slow = 1'b0;
    $display("test setup done");
  endtask
  task automatic t_init();
    rchk(rnm_pkg::A_ISTAT, 32'h4, 32'h4);
    wr_reg(rnm_pkg::A_RETRY, 32'd20);
    wr_reg(rnm_pkg::A_LIMIT, 32'd1);
    wr_reg(rnm_pkg::A_IMASK, 32'h2);
    wr_reg(rnm_pkg::A_TARGETS, 32'h06);
    wr_reg(rnm_pkg::A_REQDATA, 32'h01123456);
    i_peer.ans_mask = 8'h02;
    wr_reg(rnm_pkg::A_CTRL, 32'h1);
    get(rnm_pkg::FT_CFG_REQ);
    chk(f & 40'hf1ffffffff, {rnm_pkg::FT_CFG_REQ, 4'h1, 32'h01123456});
    get(rnm_pkg::FT_CFG_REQ);
    chk(f[39:32], {rnm_pkg::FT_CFG_REQ, 3'd2, 1'b0});
    chk(($time - t1) / 100 inside {[19:23]}, 1);
    repeat (40) @(posedge clk);
    chk(irq, 1);
    rchk(rnm_pkg::A_TGTSTAT, 32'h00000402);
    rchk(rnm_pkg::A_ISTAT, 32'h3, 32'h3);
    chk(irq, 0);
    rchk(rnm_pkg::A_ISTAT, 32'h0, 32'h3);
    wr_reg(rnm_pkg::A_TARGETS, 32'h02);
    wr_reg(rnm_pkg::A_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    rchk(rnm_pkg::A_TGTSTAT, 32'h00000002);
    // Null inquiry broadcast carries only the table index
    i_peer.q.delete();
    wr_reg(rnm_pkg::A_CTRL, 32'h3);
    get(rnm_pkg::FT_CFG_REQ);
    chk(f & 40'hf1ffffffff, {rnm_pkg::FT_CFG_REQ, 4'h1, 32'h01000000});
    $display("test initiator done");
  endtask
  task automatic t_fault();
    wr_reg(rnm_pkg::A_DESIG, 32'd6);
    fcode <= 8'h5a;
    fault <= 1'b1;
    get(rnm_pkg::FT_FLT_REP);
    chk(f & 40'hff000000ff, {rnm_pkg::FT_FLT_REP, 4'hc, 32'h5a});
    i_peer.send(rnm_pkg::FT_FLT_REQ, 3'd6, 1'b0, 32'h0);
    get(rnm_pkg::FT_FLT_RSP);
    chk(f[39:32], {rnm_pkg::FT_FLT_RSP, 3'd6, 1'b0});
    fault <= 1'b0;
    $display("test fault done");
  endtask
  task automatic t_perf();
    // Old reports would make the period check pass trivially
    i_peer.q.delete();
    get(rnm_pkg::FT_PRF_REP);
    get(rnm_pkg::FT_PRF_REP);
    chk(f, {rnm_pkg::FT_PRF_REP, 4'hc, 32'hc0ffee01});
    chk(($time - t1) / 100 <= 31, 1);
    i_peer.send(rnm_pkg::FT_PRF_REQ, 3'd6, 1'b0, 32'h0);
    get(rnm_pkg::FT_PRF_RSP);
    chk(f, {rnm_pkg::FT_PRF_RSP, 4'hc, 32'hc0ffee01});
    $display("test performance done");
  endtask
  task automatic t_standby();
    tributary_signal_fail <= 8'h08;
    repeat (6) @(posedge clk);
    chk(sel, 8'h08);
    tsfp <= 8'h08;
    repeat (6) @(posedge clk);
    chk(sel, 8'h00);
    tsfp <= 8'h00;
    werr <= 64'h0080ff0000000000;
    repeat (6) @(posedge clk);
    chk(sel, 8'h28);
    rchk(rnm_pkg::A_STATE, 32'h128, 32'h1ff);
    rchk(rnm_pkg::A_ISTAT, 32'h10, 32'h10);
    tributary_signal_fail <= 8'h00;
    werr <= 64'h0;
    repeat (6) @(posedge clk);
    chk(sel, 8'h00);
    // Clock enable low freezes the selection
    ce <= 1'b0;
    tributary_signal_fail <= 8'h01;
    repeat (6) @(posedge clk);
    chk(sel, 8'h00);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk(sel, 8'h01);
    $display("test standby done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #(100 * 20000);
    errors++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_setup();
    t_init();
    t_fault();
    t_perf();
    t_standby();
    results();
  end
endmodule
